// ### rtl/gsi_pkg.sv
// Package for the sync and interrupt control block: map, fields, states
package gsi_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_A_OFF   = 8'h00;
  localparam logic [7:0] CFG_B_OFF   = 8'h04;
  localparam logic [7:0] STAT_A_OFF  = 8'h08;
  localparam logic [7:0] STAT_B_OFF  = 8'h0c;
  localparam logic [7:0] CTRL_A_OFF  = 8'h10;
  localparam logic [7:0] CTRL_B_OFF  = 8'h14;
  localparam logic [7:0] TLSTAT_OFF  = 8'h18;
  localparam logic [7:0] TLMASK1_OFF = 8'h1c;
  localparam logic [7:0] TLMASK2_OFF = 8'h20;
  localparam logic [7:0] TLAUX_OFF   = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_CC_BIT   = 0;
  localparam int CFG_DIR_BIT  = 1;
  localparam int ST_EDGE_BIT  = 0;
  localparam int ST_LEVEL_BIT = 1;
  localparam int ST_COMP_BIT  = 2;
  localparam int ST_ERR_BIT   = 3;
  localparam int CT_IEN_BIT   = 0;
  localparam int AUX_INV_BIT  = 0;
  localparam int TL_EVENTS    = 13;
  localparam int MASK1_BITS   = 7;
  localparam int STABLE_CYC   = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] CFG_RST  = 2'h0;
  localparam logic       INV_RST  = 1'h1;
  localparam logic [12:0] MASK_RST = 13'h0000;

  // ----------------------------------------------------------------
  // Sync detector states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SD_IDLE = 3'b001,
    SD_WAIT = 3'b010,
    SD_HIGH = 3'b100
  } gsi_sd_t;

endpackage

// ### rtl/gsi_top.sv
// Two-port sync, bus error and talker/listener interrupt merge
//
// Behaviour
// - Three sources each give a falling edge on a port's control line.
// - Talker/listener interrupt high drives that port's line low.
// - Thirteen talker/listener events, each gated by one of two masks.
// - Reading talker/listener status releases its interrupt and re-arms.
// - Detector starts watching data-valid on last-byte-done rising edge.
// - No carry: done with channel 0/2 acknowledge marks last byte.
// - Done is asserted during final byte of final chained block.
// - Carry with carry-complete set: next channel 1/3 ack marks last.
// - After final carry byte, requests masked; channel never ends.
// - Direction 0: wait for data-valid rising edge, then edge out.
// - Direction 1: once data-valid level is high, edge out.
// - Bus error while master ends cycle, sets completion and error.
// - Bus error also edges the active port's control line.
// - Channels 0,1 serve port A; 2,3 serve port B.
// - Request, wait acknowledge, wait strobe, then move data.
// - Port requests go to channel 0/2 or 1/3 by carry option.
// - Control line level is readable in the channel status register.
// - Falling edge stable two clocks sets the edge-seen flag.
// - Edge-seen raises interrupt whenever interrupt enable is set, before or after.
// - 24-bit address, 16-bit data, page register gives 32-bit.
// - Carry off: all requests go to channel 0 or 2 only.
`timescale 1ns/1ps

module gsi_top (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Talker/listener side
  input  wire logic [12:0] tl_event,
  input  wire logic [1:0]  tl_dma_req,
  output logic      [1:0]  tl_dma_ack_n,
  output logic      [1:0]  tl_irq,
  input  wire logic        dav_n,
  // DMA controller side
  input  wire logic        done_n,
  input  wire logic        chan0_ack_n,
  input  wire logic        chan1_ack_n,
  input  wire logic        chan2_ack_n,
  input  wire logic        chan3_ack_n,
  input  wire logic        bus_exc_code_n,
  input  wire logic        bus_master,
  output logic      [3:0]  chan_req_n,
  output logic             periph_ctl_line_a,
  output logic             periph_ctl_line_b,
  output logic      [1:0]  chan_irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0][1:0]  cfg;
    logic [1:0]       ien;
    logic [1:0]       edge_seen;
    logic [1:0]       comp;
    logic [1:0]       err;
    logic [1:0]       irq_polarity_bit;
    logic [1:0][12:0] mask;
    logic [1:0][12:0] pend;
    logic [1:0]       tlirq;
    logic [1:0]       carry_done;
    logic [1:0]       cc_mask;
    logic [1:0]       lbd;
    gsi_pkg::gsi_sd_t [1:0] sd;
    logic [1:0]       sync_ev;
    logic [1:0]       berr_ev;
    logic             dav_q;
    logic             bec_q;
    logic [3:0]       ack_q;
    logic [1:0]       pcl;
    logic [1:0][1:0]  pcl_hist;
    logic [1:0]       reqv;
    logic [1:0]       ackv;
    logic [3:0]       req;
    logic [1:0]       cirq;
    logic [31:0]      rdata;
    logic             ready;
    logic             slverr;
  } gsi_st_t;

  gsi_st_t s_q;
  gsi_st_t s_d;

  // Byte address to register decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  logic [3:0] ack;
  assign ack = ~{chan3_ack_n, chan2_ack_n, chan1_ack_n, chan0_ack_n};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic       acc;
    logic       wr;
    logic       rd;
    logic       port;
    logic       lbd_now;
    logic [3:0] ack_rise;
    logic [1:0] tl_rd;
    s_d = s_q;
    acc = psel && penable && !s_q.ready;
    wr = acc && pwrite;
    rd = acc && !pwrite;
    port = 1'b0;
    lbd_now = 1'b0;
    ack_rise = ack & ~s_q.ack_q;
    tl_rd = 2'b00;
    s_d.ready = acc;
    s_d.slverr = 1'b0;
    s_d.dav_q = dav_n;
    s_d.bec_q = bus_exc_code_n;
    s_d.ack_q = ack;
    if (acc)
    begin
      s_d.rdata = 32'h0000_0000;
      port = paddr[2];
      if (hit(paddr, gsi_pkg::CFG_A_OFF) || hit(paddr, gsi_pkg::CFG_B_OFF))
      begin
        if (wr)
          s_d.cfg[port] = pwdata[1:0];
        s_d.rdata[1:0] = s_q.cfg[port];
      end
      else if (hit(paddr, gsi_pkg::STAT_A_OFF)
               || hit(paddr, gsi_pkg::STAT_B_OFF))
      begin
        // Writing one clears flags; set below still wins
        s_d.rdata[gsi_pkg::ST_EDGE_BIT] = s_q.edge_seen[port];
        s_d.rdata[gsi_pkg::ST_LEVEL_BIT] = s_q.pcl[port];
        s_d.rdata[gsi_pkg::ST_COMP_BIT] = s_q.comp[port];
        s_d.rdata[gsi_pkg::ST_ERR_BIT] = s_q.err[port];
        if (wr)
        begin
          if (pwdata[gsi_pkg::ST_EDGE_BIT])
            s_d.edge_seen[port] = 1'b0;
          if (pwdata[gsi_pkg::ST_COMP_BIT])
            s_d.comp[port] = 1'b0;
          if (pwdata[gsi_pkg::ST_ERR_BIT])
            s_d.err[port] = 1'b0;
        end
      end
      else if (hit(paddr, gsi_pkg::CTRL_A_OFF)
               || hit(paddr, gsi_pkg::CTRL_B_OFF))
      begin
        if (wr)
          s_d.ien[port] = pwdata[gsi_pkg::CT_IEN_BIT];
        s_d.rdata[gsi_pkg::CT_IEN_BIT] = s_q.ien[port];
      end
      else if (hit(paddr, gsi_pkg::TLSTAT_OFF))
      begin
        // Status read releases both ports: A in [12:0], B in [28:16]
        if (rd)
          tl_rd = 2'b11;
        s_d.rdata[12:0] = s_q.pend[0];
        s_d.rdata[28:16] = s_q.pend[1];
      end
      else if (hit(paddr, gsi_pkg::TLMASK1_OFF))
      begin
        // Mask one: port A in [6:0], port B in [14:8]
        if (wr)
        begin
          s_d.mask[0][gsi_pkg::MASK1_BITS-1:0] = pwdata[6:0];
          s_d.mask[1][gsi_pkg::MASK1_BITS-1:0] = pwdata[14:8];
        end
        s_d.rdata[6:0] = s_q.mask[0][gsi_pkg::MASK1_BITS-1:0];
        s_d.rdata[14:8] = s_q.mask[1][gsi_pkg::MASK1_BITS-1:0];
      end
      else if (hit(paddr, gsi_pkg::TLMASK2_OFF)
               || hit(paddr, gsi_pkg::TLAUX_OFF))
      begin
        // Offset 20: mask two for both ports; 24: one polarity bit per port
        if (hit(paddr, gsi_pkg::TLMASK2_OFF))
        begin
          if (wr)
          begin
            s_d.mask[0][12:gsi_pkg::MASK1_BITS] = pwdata[5:0];
            s_d.mask[1][12:gsi_pkg::MASK1_BITS] = pwdata[13:8];
          end
          s_d.rdata[5:0] = s_q.mask[0][12:gsi_pkg::MASK1_BITS];
          s_d.rdata[13:8] = s_q.mask[1][12:gsi_pkg::MASK1_BITS];
        end
        else
        begin
          if (wr)
            s_d.irq_polarity_bit = pwdata[1:0];
          s_d.rdata[1:0] = s_q.irq_polarity_bit;
        end
      end
      else
        s_d.slverr = 1'b1;
    end
    for (int p = 0; p < 2; p++)
    begin
      // Talker/listener interrupt latch
      s_d.pend[p] = (s_q.pend[p] & ~{13{tl_rd[p]}})
                    | (tl_event & s_q.mask[p]);
      s_d.tlirq[p] = (s_d.pend[p] != 13'h0000) ^ s_q.irq_polarity_bit[p];
      // Carry complete flop: set at end of carry byte, cleared at end
      // of last byte on channel 1/3
      if (!ack[2*p+1] && s_q.ack_q[2*p+1] && s_q.cfg[p][0])
      begin
        // Release after the last byte masks further requests
        if (s_q.carry_done[p])
          s_d.cc_mask[p] = 1'b1;
        s_d.carry_done[p] = !s_q.carry_done[p];
      end
      if (!s_q.cfg[p][gsi_pkg::CFG_CC_BIT])
      begin
        s_d.carry_done[p] = 1'b0;
        s_d.cc_mask[p] = 1'b0;
      end
      // Last byte done
      if (s_q.cfg[p][gsi_pkg::CFG_CC_BIT])
        lbd_now = s_q.carry_done[p] && ack_rise[2*p+1];
      else
        lbd_now = !done_n && ack[2*p];
      s_d.lbd[p] = lbd_now;
      s_d.sync_ev[p] = 1'b0;
      // Sync detector, one event per arm
      unique case (s_q.sd[p])
        gsi_pkg::SD_IDLE:
          if (lbd_now && !s_q.lbd[p])
            s_d.sd[p] = gsi_pkg::SD_WAIT;
        gsi_pkg::SD_WAIT:
          if (s_q.cfg[p][gsi_pkg::CFG_DIR_BIT])
          begin
            if (dav_n)
            begin
              s_d.sync_ev[p] = 1'b1;
              s_d.sd[p] = gsi_pkg::SD_IDLE;
            end
          end
          else if (!dav_n)
            s_d.sd[p] = gsi_pkg::SD_HIGH;
        gsi_pkg::SD_HIGH:
          if (dav_n && !s_q.dav_q)
          begin
            s_d.sync_ev[p] = 1'b1;
            s_d.sd[p] = gsi_pkg::SD_IDLE;
          end
        default:
          s_d.sd[p] = gsi_pkg::SD_IDLE;
      endcase
      // Bus error on active port
      s_d.berr_ev[p] = !bus_exc_code_n && bus_master
                       && (ack[2*p] || ack[2*p+1]);
      if (s_d.berr_ev[p])
      begin
        s_d.comp[p] = 1'b1;
        s_d.err[p] = 1'b1;
      end
      // Merge: any source holds line low
      s_d.pcl[p] = !(s_q.tlirq[p] || s_q.sync_ev[p]
                     || s_q.berr_ev[p]);
      s_d.pcl_hist[p] = {s_q.pcl_hist[p][0], s_q.pcl[p]};
      if (s_q.pcl_hist[p] == 2'b10 && !s_q.pcl[p])
        s_d.edge_seen[p] = 1'b1;
      s_d.cirq[p] = s_q.ien[p] && s_q.edge_seen[p];
      // Request gating and acknowledge
      s_d.reqv[p] = tl_dma_req[p] && !s_q.cc_mask[p];
      s_d.req[2*p] = !(s_d.reqv[p] && !s_q.cfg[p][0]);
      s_d.req[2*p+1] = !(s_d.reqv[p] && s_q.cfg[p][0]);
      s_d.ackv[p] = ack[2*p] || (ack[2*p+1] && s_q.carry_done[p]);
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
      s_q.cfg <= {gsi_pkg::CFG_RST, gsi_pkg::CFG_RST};
      s_q.irq_polarity_bit <= {gsi_pkg::INV_RST, gsi_pkg::INV_RST};
      s_q.mask <= {gsi_pkg::MASK_RST, gsi_pkg::MASK_RST};
      s_q.sd[0] <= gsi_pkg::SD_IDLE;
      s_q.sd[1] <= gsi_pkg::SD_IDLE;
      s_q.dav_q <= 1'b1;
      s_q.bec_q <= 1'b1;
      s_q.pcl <= 2'b11;
      s_q.pcl_hist <= {2'b11, 2'b11};
      s_q.req <= 4'hf;
      s_q.tlirq <= 2'b11;
    end
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.slverr;
  assign tl_dma_ack_n = ~s_q.ackv;
  assign tl_irq = s_q.tlirq;
  assign chan_req_n = s_q.req;
  assign periph_ctl_line_a = s_q.pcl[0];
  assign periph_ctl_line_b = s_q.pcl[1];
  assign chan_irq = s_q.cirq;

endmodule

// ### tb/gsi_properties.sv
// Checker for the sync and interrupt control block
`timescale 1ns/1ps
module gsi_properties (
  // Clock, reset
  input wire logic       pclk,
  input wire logic       presetn,
  // APB
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  // Event lines
  input wire logic [1:0] tl_irq,
  input wire logic       periph_ctl_line_a,
  input wire logic       periph_ctl_line_b,
  input wire logic [3:0] chan_req_n,
  input wire logic       chan2_ack_n,
  input wire logic       bus_exc_code_n,
  input wire logic       bus_master
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_ready_wait; psel && penable && !pready |=> pready; endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("no pready");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready long");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("stray pslverr");
  property p_tl_a; $rose(tl_irq[0]) |=> !periph_ctl_line_a; endproperty
  a_tl_a: assert property (p_tl_a) else $error("line a stays high");
  property p_tl_b; $rose(tl_irq[1]) |=> !periph_ctl_line_b; endproperty
  a_tl_b: assert property (p_tl_b) else $error("line b stays high");
  property p_route_a; !chan_req_n[0] |-> chan_req_n[1]; endproperty
  a_route_a: assert property (p_route_a) else $error("two a requests");
  property p_route_b; !chan_req_n[2] |-> chan_req_n[3]; endproperty
  a_route_b: assert property (p_route_b) else $error("two b requests");
  property p_berr_b;
    !bus_exc_code_n && bus_master && !chan2_ack_n |-> ##[1:3] !periph_ctl_line_b;
  endproperty
  a_berr_b: assert property (p_berr_b) else $error("no error edge");
  c_err: cover property (pready && pslverr);
  c_fall_a: cover property ($fell(periph_ctl_line_a));
  c_fall_b: cover property ($fell(periph_ctl_line_b));
endmodule

// ### tb/gsi_dma_model.sv
// Behavioural model of the DMA controller channels
`timescale 1ns/1ps
module gsi_dma_model (
  // Clock, reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Channels
  input  wire logic [3:0] chan_req_n,
  output logic      [3:0] chan_ack_n,
  output logic            done_n,
  output logic            bus_exc_code_n,
  output logic            bus_master,
  // Scenario controls
  input  wire logic       last_byte,
  input  wire logic       bus_err,
  input  wire logic       slow
);
  logic [2:0] cnt;
  logic [1:0] ch;
  logic       act;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cnt <= 3'h0;
      ch  <= 2'h0;
    end
    else if (cnt == 3'h0 && chan_req_n != 4'hf)
    begin
      ch  <= !chan_req_n[0] ? 2'h0 : !chan_req_n[1] ? 2'h1 :
             !chan_req_n[2] ? 2'h2 : 2'h3;
      cnt <= slow ? 3'h6 : 3'h3;
    end
    else if (cnt != 3'h0)
      cnt <= cnt - 3'h1;
  assign act            = (cnt == 3'h1) || (cnt == 3'h2);
  assign chan_ack_n     = act ? ~(4'h1 << ch) : 4'hf;
  assign done_n         = !(act && last_byte);
  assign bus_master     = cnt != 3'h0;
  assign bus_exc_code_n = !(act && bus_err);
endmodule

// ### tb/gsi_top_test.sv
// Self-checking testbench for the sync and interrupt control block
`timescale 1ns/1ps
module gsi_top_test;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, pw;
  logic [12:0] tl_event;
  logic [1:0]  tl_dma_req, tl_dma_ack_n, tl_irq, chan_irq;
  logic        dav_n, done_n, bus_exc_code_n, bus_master, er;
  logic        last_byte, bus_err, slow, pcl_a, pcl_b;
  logic [3:0]  chan_ack_n, chan_req_n;
  logic [7:0]  mon;
  int          n_fail, comparisons, seed, cycles;
  assign mon = {chan_req_n, chan_irq, pcl_b, pcl_a};
  gsi_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tl_event(tl_event), .tl_dma_req(tl_dma_req),
    .tl_dma_ack_n(tl_dma_ack_n), .tl_irq(tl_irq), .dav_n(dav_n),
    .done_n(done_n), .chan0_ack_n(chan_ack_n[0]),
    .chan1_ack_n(chan_ack_n[1]), .chan2_ack_n(chan_ack_n[2]),
    .chan3_ack_n(chan_ack_n[3]), .bus_exc_code_n(bus_exc_code_n),
    .bus_master(bus_master), .chan_req_n(chan_req_n),
    .periph_ctl_line_a(pcl_a), .periph_ctl_line_b(pcl_b),
    .chan_irq(chan_irq));
  gsi_dma_model partner (.pclk(pclk), .presetn(presetn),
    .chan_req_n(chan_req_n), .chan_ack_n(chan_ack_n), .done_n(done_n),
    .bus_exc_code_n(bus_exc_code_n), .bus_master(bus_master),
    .last_byte(last_byte), .bus_err(bus_err), .slow(slow));
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      end_sim;
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] exp_cfg(input logic [31:0] d);
    return {30'h0, d[1:0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge pclk);
    end
    if (n >= 20)
      n_fail++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_mon(input int i, input logic v);
    int n;
    n = 0;
    @(negedge pclk);
    while (mon[i] !== v && n < 40)
    begin
      n++;
      @(negedge pclk);
    end
    chk({31'h0, mon[i]}, {31'h0, v});
    @(posedge pclk);
  endtask
  task automatic end_sim;
    $display("checks %0d fails %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, tl_event, tl_dma_req} = '0;
    {last_byte, bus_err, slow, presetn, n_fail, comparisons} = '0;
    dav_n = 1'b1;
    seed = 19;
    repeat (6) @(posedge pclk);
    chk({24'h0, mon}, 32'hf3);
    presetn <= 1'b1;
    apb(0, gsi_pkg::CFG_A_OFF, 32'h0);
    chk(rd, exp_cfg(32'h0));
    apb(0, 8'hf0, 32'h0);
    chk({31'h0, er}, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      pw = $random(seed);
      apb(1, gsi_pkg::CFG_B_OFF, pw);
      apb(0, gsi_pkg::CFG_B_OFF, 32'h0);
      chk(rd, exp_cfg(pw));
    end
    $display("registers done");
    apb(1, gsi_pkg::TLAUX_OFF, 32'h0);
    wait_mon(0, 1'b1);
    apb(1, gsi_pkg::TLMASK1_OFF, 32'hff);
    apb(1, gsi_pkg::TLMASK2_OFF, 32'h3f);
    apb(1, gsi_pkg::STAT_A_OFF, 32'h1);
    apb(1, gsi_pkg::CTRL_A_OFF, 32'h1);
    tl_event <= 13'h1 << ($unsigned($random(seed)) % 13);
    wait_mon(0, 1'b0);
    wait_mon(2, 1'b1);
    tl_event <= 13'h0;
    apb(0, gsi_pkg::TLSTAT_OFF, 32'h0);
    wait_mon(0, 1'b1);
    apb(1, gsi_pkg::STAT_A_OFF, 32'h1);
    wait_mon(2, 1'b0);
    $display("talker interrupt done");
    apb(1, gsi_pkg::CFG_A_OFF, 32'h2);
    last_byte  <= 1'b1;
    tl_dma_req <= 2'b01;
    wait_mon(4, 1'b0);
    wait_mon(0, 1'b0);
    tl_dma_req <= 2'b00;
    wait_mon(0, 1'b1);
    $display("sync dir one done");
    apb(1, gsi_pkg::CFG_A_OFF, 32'h0);
    slow       <= 1'b1;
    tl_dma_req <= 2'b01;
    repeat (4) @(posedge pclk);
    tl_dma_req <= 2'b00;
    repeat (6) @(posedge pclk);
    dav_n <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({31'h0, pcl_a}, 32'h1);
    dav_n <= 1'b1;
    wait_mon(0, 1'b0);
    $display("sync dir zero done");
    apb(1, gsi_pkg::CFG_A_OFF, 32'h1);
    tl_dma_req <= 2'b01;
    wait_mon(5, 1'b0);
    tl_dma_req <= 2'b00;
    apb(1, gsi_pkg::CFG_B_OFF, 32'h0);
    bus_err    <= 1'b1;
    tl_dma_req <= 2'b10;
    wait_mon(1, 1'b0);
    tl_dma_req <= 2'b00;
    bus_err    <= 1'b0;
    apb(0, gsi_pkg::STAT_B_OFF, 32'h0);
    chk(rd & 32'hc, 32'hc);
    $display("bus error done");
    end_sim;
  end
endmodule
bind gsi_top gsi_properties u_prop (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .tl_irq(tl_irq), .periph_ctl_line_a(periph_ctl_line_a),
  .periph_ctl_line_b(periph_ctl_line_b), .chan_req_n(chan_req_n),
  .chan2_ack_n(chan2_ack_n), .bus_exc_code_n(bus_exc_code_n),
  .bus_master(bus_master));
